// ---- xfer_pkg.sv ----
/*
 * Shared constants and carrier types for the two-word transfer port
 * between the integer core and the floating-point register file.
 * Assumes a 32-bit instruction word and a 32-entry single register file.
 */
package xfer_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned WORD_W    = 32;
    localparam int unsigned SREG_N    = 32;
    localparam int unsigned SIDX_W    = 5;
    localparam int unsigned CREG_W    = 4;

    // ------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------
    localparam int unsigned COND_HI   = 31;
    localparam int unsigned COND_LO   = 28;
    localparam int unsigned OPC_HI    = 27;
    localparam int unsigned OPC_LO    = 21;
    localparam int unsigned DIR_BIT   = 20;
    localparam int unsigned SECOND_HI = 19;
    localparam int unsigned SECOND_LO = 16;
    localparam int unsigned FIRST_HI  = 15;
    localparam int unsigned FIRST_LO  = 12;
    localparam int unsigned PREC_HI   = 11;
    localparam int unsigned PREC_LO   = 8;
    localparam int unsigned EXTRA_BIT = 5;
    localparam int unsigned ONE_BIT   = 4;
    localparam int unsigned REG_HI    = 3;
    localparam int unsigned REG_LO    = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [6:0] OPC_PAIR_XFER    = 7'h62;
    localparam logic [3:0] PREC_DOUBLE      = 4'hB;
    localparam logic [3:0] PREC_SINGLE      = 4'hA;
    localparam logic [3:0] COND_ALWAYS      = 4'hE;
    localparam logic [3:0] REG_FIELD_TOP    = 4'hF;
    localparam logic [WORD_W-1:0] RF_RESET  = 32'h0000_0000;

    // Flag positions within the nzcv input
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] instr;
        logic [WORD_W-1:0] first_data;
        logic [WORD_W-1:0] second_data;
    } req_type;

    typedef struct packed {
        logic [CREG_W-1:0] first_reg;
        logic [CREG_W-1:0] second_reg;
        logic [WORD_W-1:0] first_data;
        logic [WORD_W-1:0] second_data;
    } resp_type;

endpackage

// ---- pair_xfer.sv ----
/*
 * Two-word transfer unit: moves 64 bits per instruction between two
 * core registers and the floating-point register file held here.
 * Assumes the core presents one instruction per request pulse with
 * both source values and its current flags, and consumes the answer
 * pulse one cycle later.
 */
// Function
// RULE1: Core-to-double: second word high, first low
// RULE2: Double-to-core: low to first, high to second
// RULE3: Core-to-single: second to m, first to m+1
// RULE4: Single-to-core: m+1 to first, m to second
// RULE5: Pair start is field bits plus extra bit
// RULE6: Issuer never encodes a pair starting at 31
// RULE7: Issuer never names PC as destination
// RULE8: Transfer acts only when condition passes
// RULE9: Bit patterns copied without any conversion
// RULE10: Core registers decoded independently, any numbers
// RULE11: Opcode and precision field decode
// RULE12: Transfers never raise any exception flag
`timescale 1ns/10ps
`default_nettype none

module pair_xfer
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           req_valid_i,
    input  wire xfer_pkg::req_type              req_i,
    input  wire logic [3:0]                     nzcv_i,
    input  wire logic [xfer_pkg::SIDX_W-1:0]    rf_rd_idx_i,
    output var  logic [xfer_pkg::WORD_W-1:0]    rf_rd_data_o,
    output var  logic                           resp_valid_o,
    output var  xfer_pkg::resp_type             resp_o,
    output var  logic                           wr_done_o,
    output var  logic                           cond_fail_o,
    output var  logic                           reject_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Flag tests use the flags that arrive with the request
    function automatic logic cond_pass(
        input logic [3:0] cond,
        input logic [3:0] f);
        logic n;
        logic z;
        logic c;
        logic v;
        logic r;
        n = f[xfer_pkg::FLAG_N];
        z = f[xfer_pkg::FLAG_Z];
        c = f[xfer_pkg::FLAG_C];
        v = f[xfer_pkg::FLAG_V];
        case (cond[3:1])
            3'h0:    r = z;
            3'h1:    r = c;
            3'h2:    r = n;
            3'h3:    r = v;
            3'h4:    r = c & ~z;
            3'h5:    r = (n == v);
            3'h6:    r = ~z & (n == v);
            default: r = 1'b1;
        endcase
        // Odd codes invert; the all-ones code never passes
        if (cond == xfer_pkg::COND_ALWAYS)
            cond_pass = 1'b1;
        else if (cond[3:1] == 3'h7)
            cond_pass = 1'b0;
        else
            cond_pass = r ^ cond[0];
    endfunction

    // Wraps at 31; the pair from 31 is refused before it matters
    function automatic logic [xfer_pkg::SIDX_W-1:0] next_idx(
        input logic [xfer_pkg::SIDX_W-1:0] i);
        next_idx = i + 5'h01;
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Asserts at once, releases two edges later to keep off the edge
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic [3:0]                  cond_w    = req_i.instr[xfer_pkg::COND_HI:xfer_pkg::COND_LO];
    wire logic [6:0]                  opc_w     = req_i.instr[xfer_pkg::OPC_HI:xfer_pkg::OPC_LO];
    wire logic                        to_core_w = req_i.instr[xfer_pkg::DIR_BIT];
    wire logic [3:0]                  prec_w    = req_i.instr[xfer_pkg::PREC_HI:xfer_pkg::PREC_LO];
    wire logic [3:0]                  reg_fld_w = req_i.instr[xfer_pkg::REG_HI:xfer_pkg::REG_LO];
    wire logic                        extra_w   = req_i.instr[xfer_pkg::EXTRA_BIT];
    // Each core register from its own field; no adjacency assumed
    wire logic [xfer_pkg::CREG_W-1:0] first_w   =
        req_i.instr[xfer_pkg::FIRST_HI:xfer_pkg::FIRST_LO]; // RULE10
    wire logic [xfer_pkg::CREG_W-1:0] second_w  =
        req_i.instr[xfer_pkg::SECOND_HI:xfer_pkg::SECOND_LO]; // RULE10

    // Bits 7:6 are not checked; both precisions share the rest
    wire logic is_double_w = (prec_w == xfer_pkg::PREC_DOUBLE); // RULE11
    wire logic is_single_w = (prec_w == xfer_pkg::PREC_SINGLE); // RULE11
    wire logic opc_ok_w    = (opc_w == xfer_pkg::OPC_PAIR_XFER)
                           & req_i.instr[xfer_pkg::ONE_BIT]
                           & (is_double_w | is_single_w); // RULE11

    // Pair from 31 would wrap into 0; refused rather than guessed
    wire logic s31_w = is_single_w & extra_w & (reg_fld_w == xfer_pkg::REG_FIELD_TOP); // RULE6

    // Refused requests leave every register untouched
    wire logic legal_w = opc_ok_w & ~s31_w;
    wire logic pass_w  = cond_pass(cond_w, nzcv_i); // RULE8
    wire logic go_w    = req_valid_i & legal_w & pass_w; // RULE8

    // Low index of the pair, high index is the next one
    wire logic [xfer_pkg::SIDX_W-1:0] lo_idx_w = is_double_w ? {reg_fld_w, 1'b0}
                                                             : {reg_fld_w, extra_w}; // RULE5
    wire logic [xfer_pkg::SIDX_W-1:0] hi_idx_w = next_idx(lo_idx_w);

    // Double: first word is the low half; single: first word is m+1
    wire logic [xfer_pkg::SIDX_W-1:0] first_idx_w  =
        is_double_w ? lo_idx_w : hi_idx_w; // RULE1 RULE3
    wire logic [xfer_pkg::SIDX_W-1:0] second_idx_w =
        is_double_w ? hi_idx_w : lo_idx_w; // RULE1 RULE3

    // ------------------------------------------------------------
    // Direction and status
    // ------------------------------------------------------------
    wire logic write_w  = go_w & ~to_core_w;
    wire logic read_w   = go_w & to_core_w;
    wire logic fail_w   = req_valid_i & legal_w & ~pass_w; // RULE8
    wire logic refuse_w = req_valid_i & ~legal_w; // RULE11

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [xfer_pkg::WORD_W-1:0] rf_q [xfer_pkg::SREG_N];

    // Raw copy, no format handling; no exception state exists here
    always_ff @(posedge clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            for (int i = 0; i < xfer_pkg::SREG_N; i++)
                rf_q[i] <= xfer_pkg::RF_RESET;
        end
        else if (write_w)
        begin
            rf_q[first_idx_w]  <= req_i.first_data; // RULE1 RULE3 RULE9 RULE12
            rf_q[second_idx_w] <= req_i.second_data; // RULE1 RULE3 RULE9
        end
    end

    // ------------------------------------------------------------
    // Answer to the core
    // ------------------------------------------------------------
    xfer_pkg::resp_type resp_d;

    always_comb
    begin
        resp_d.first_reg   = first_w;
        resp_d.second_reg  = second_w;
        resp_d.first_data  = rf_q[first_idx_w]; // RULE2 RULE4 RULE9
        resp_d.second_data = rf_q[second_idx_w]; // RULE2 RULE4 RULE9
    end

    // Pulses last one cycle; exactly one follows each request
    always_ff @(posedge clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            resp_valid_o <= 1'b0;
            wr_done_o    <= 1'b0;
            cond_fail_o  <= 1'b0;
            reject_o     <= 1'b0;
        end
        else
        begin
            resp_valid_o <= read_w; // RULE2 RULE4
            wr_done_o    <= write_w; // RULE1 RULE3
            cond_fail_o  <= fail_w; // RULE8
            reject_o     <= refuse_w; // RULE11
        end
    end

    // PC as destination is forwarded as named; the core owns that case
    // Held until the next read, so a slow core can still take it
    always_ff @(posedge clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            resp_o <= '0;
        else if (read_w)
            resp_o <= resp_d; // RULE2 RULE4
    end

    // ------------------------------------------------------------
    // Observation port
    // ------------------------------------------------------------
    // Registered read, one cycle behind the index
    always_ff @(posedge clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            rf_rd_data_o <= xfer_pkg::RF_RESET;
        else
            rf_rd_data_o <= rf_q[rf_rd_idx_i];
    end

endmodule

`default_nettype wire

// ---- pair_xfer_assertions.sv ----
/* Port checker for pair_xfer: answer kind, refusals, register naming.
   Bound to every pair_xfer instance; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module pair_xfer_assertions
(
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               req_valid_i,
    input wire xfer_pkg::req_type  req_i,
    input wire logic               resp_valid_o,
    input wire xfer_pkg::resp_type resp_o,
    input wire logic               wr_done_o,
    input wire logic               cond_fail_o,
    input wire logic               reject_o
);
    wire logic [31:0] i_w = req_i.instr;
    wire logic [3:0]  o_w = {resp_valid_o, wr_done_o, cond_fail_o, reject_o};
    wire logic        s31_w = i_w[11:8] == xfer_pkg::PREC_SINGLE && i_w[5] && &i_w[3:0];
    wire logic        ok_w = i_w[27:21] == xfer_pkg::OPC_PAIR_XFER && i_w[4] && !s31_w
                             && i_w[11:9] == 3'h5;
    wire logic        go_w = req_valid_i && ok_w && i_w[31:28] == xfer_pkg::COND_ALWAYS;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_ONE: assert property (req_valid_i |=> $onehot(o_w))
        else $error("answer count");
    AST_IDLE: assert property (!req_valid_i |=> o_w == 4'h0)
        else $error("answer without request");
    AST_BAD: assert property (req_valid_i && !ok_w |=> reject_o)
        else $error("bad encoding kept");
    AST_TOP: assert property (req_valid_i && s31_w |=> reject_o)
        else $error("pair from 31 kept");
    AST_NEVER: assert property (req_valid_i && ok_w && &i_w[31:28] |=> cond_fail_o)
        else $error("never condition ran");
    AST_WR: assert property (go_w && !i_w[20] |=> wr_done_o)
        else $error("write not done");
    AST_RD: assert property (go_w && i_w[20] |=> resp_valid_o &&
        resp_o.first_reg == $past(i_w[15:12]) && resp_o.second_reg == $past(i_w[19:16]))
        else $error("read answer wrong");
    AST_HOLD: assert property (!resp_valid_o |-> $stable(resp_o))
        else $error("answer moved");
endmodule
bind pair_xfer pair_xfer_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .wr_done_o(wr_done_o), .cond_fail_o(cond_fail_o), .reject_o(reject_o));
`default_nettype wire

// ---- core_model.sv ----
/* Issuing core model: register bank that feeds transfers and takes answers.
   Assumes requests are pulses and answers come one cycle later. */
`timescale 1ns/10ps
`default_nettype none
module core_model
(
    input  wire logic               clk_i,
    input  wire logic               issue_i,
    input  wire logic [31:0]        instr_i,
    output var  logic               req_valid_o,
    output var  xfer_pkg::req_type  req_o,
    input  wire logic               resp_valid_i,
    input  wire xfer_pkg::resp_type resp_i
);
    logic [31:0] regs_q [16];
    wire xfer_pkg::req_type r_w =
        {instr_i, regs_q[instr_i[15:12]], regs_q[instr_i[19:16]]};
    initial
    begin
        for (int k = 0; k < 16; k++)
            regs_q[k] = {k[3:0], 28'h3C5_A96E};
    end
    // Inverted data when idle, so stale values never pass
    assign req_valid_o = issue_i;
    assign req_o = issue_i ? r_w : ~r_w;
    always @(posedge clk_i)
    begin
        if (resp_valid_i && resp_i.first_reg != 4'hF)
            regs_q[resp_i.first_reg] <= resp_i.first_data;
        if (resp_valid_i && resp_i.second_reg != 4'hF)
            regs_q[resp_i.second_reg] <= resp_i.second_data;
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* Testbench for pair_xfer driven by core_model.
   Checker is bound to the design from its own file. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [3:0]  CA = xfer_pkg::COND_ALWAYS;
    localparam logic [15:0] PASS_MAP = 16'h66A5;
    localparam logic [15:0] PASS_ALT = 16'h6996;
    logic clk_i = 1'b0, rst_n_i = 1'b0, issue = 1'b0;
    logic [31:0] instr = 32'h0, rd_data;
    logic [3:0] nzcv = 4'h6;
    logic [4:0] rd_idx = 5'h00;
    logic req_valid, resp_valid, wr_done, cond_fail, reject;
    xfer_pkg::req_type req;
    xfer_pkg::resp_type resp;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #25 clk_i = ~clk_i;
    core_model u_core (.clk_i(clk_i), .issue_i(issue), .instr_i(instr), .req_valid_o(req_valid),
        .req_o(req), .resp_valid_i(resp_valid), .resp_i(resp));
    pair_xfer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid), .req_i(req),
        .nzcv_i(nzcv), .rf_rd_idx_i(rd_idx), .rf_rd_data_o(rd_data), .resp_valid_o(resp_valid),
        .resp_o(resp), .wr_done_o(wr_done), .cond_fail_o(cond_fail), .reject_o(reject));
    function automatic logic [31:0] cv(input logic [3:0] k);
        return {k, 28'h3C5_A96E};
    endfunction
    function automatic logic [31:0] enc(logic [3:0] c, logic d, logic w, logic [3:0] f,
        logic [3:0] s, logic [4:0] v);
        return {c, xfer_pkg::OPC_PAIR_XFER, d, s, f, 3'h5, w, 2'h0, !w & v[0], 1'b1,
            w ? v[3:0] : v[4:1]};
    endfunction
    task automatic chk_w(logic [31:0] g, logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic op(logic [31:0] i, logic [3:0] e);
        @(posedge clk_i);
        #1 issue = 1'b1;
        instr = i;
        @(posedge clk_i);
        #1 issue = 1'b0;
        chk_w({28'h0, resp_valid, wr_done, cond_fail, reject}, {28'h0, e});
        @(posedge clk_i);
        #1;
    endtask
    task automatic obs(logic [4:0] x, logic [31:0] e);
        @(posedge clk_i);
        #1 rd_idx = x;
        @(posedge clk_i);
        #1 chk_w(rd_data, e);
    endtask
    // Two flag sets; codes 0, 1, 4, 5 and 8 to 11 are seen both passing and failing
    task automatic t_cond();
        logic [15:0] m;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk_i);
            #1 nzcv = p[0] ? 4'hA : 4'h6;
            m = p[0] ? PASS_ALT : PASS_MAP;
            for (int c = 0; c < 16; c++)
                op(enc(c[3:0], 1'b0, 1'b1, c[3:0], 4'h0, 5'h01), m[c] ? 4'h4 : 4'h2);
            obs(5'h02, cv(4'hE));
        end
    endtask
    task automatic t_double();
        op(enc(CA, 1'b0, 1'b1, 4'h2, 4'h9, 5'h03), 4'h4);
        obs(5'h06, cv(4'h2));
        obs(5'h07, cv(4'h9));
        op(enc(CA, 1'b1, 1'b1, 4'h4, 4'hB, 5'h03), 4'h8);
        chk_w(u_core.regs_q[4], cv(4'h2));
        chk_w(u_core.regs_q[11], cv(4'h9));
        op(enc(CA, 1'b0, 1'b1, 4'h7, 4'h8, 5'h03) ^ 32'h0100_0000, 4'h1);
        op(enc(CA, 1'b0, 1'b1, 4'h7, 4'h8, 5'h03) & 32'hFFFF_FFEF, 4'h1);
        obs(5'h06, cv(4'h2));
    endtask
    task automatic t_single();
        op(enc(CA, 1'b0, 1'b0, 4'h1, 4'h3, 5'h05), 4'h4);
        obs(5'h05, cv(4'h3));
        obs(5'h06, cv(4'h1));
        op(enc(CA, 1'b1, 1'b0, 4'hC, 4'hD, 5'h05), 4'h8);
        chk_w(u_core.regs_q[12], cv(4'h1));
        chk_w(u_core.regs_q[13], cv(4'h3));
        op(enc(CA, 1'b0, 1'b0, 4'h5, 4'h6, 5'h1E), 4'h4);
        op(enc(CA, 1'b0, 1'b0, 4'h7, 4'h8, 5'h1F), 4'h1);
        obs(5'h1F, cv(4'h5));
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Run needs about 160 cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        t_cond();
        t_double();
        t_single();
        final_report();
    end
endmodule
`default_nettype wire
